// >>> logic/eosc_pkg.sv
// Package: register map, field layout and mode codes of the clock control
package eosc_pkg;

    // ============================================================
    // Register addresses in the special function register space
    localparam logic [7:0] EOSC_ADDR_CLK_SRC  = 8'hA9;
    localparam logic [7:0] EOSC_ADDR_INT_CTRL = 8'hB2;
    localparam logic [7:0] EOSC_ADDR_EXT_CTRL = 8'hB1;

    // ============================================================
    // Reset values
    localparam logic [7:0] EOSC_RST_CLK_SRC  = 8'h00;
    localparam logic [7:0] EOSC_RST_INT_CTRL = 8'hC0;
    localparam logic [7:0] EOSC_RST_EXT_CTRL = 8'h00;

    // ============================================================
    // Field positions
    localparam int EOSC_SRC_SEL_BIT   = 0;
    localparam int EOSC_XVALID_BIT    = 7;
    localparam int EOSC_MODE_LSB      = 4;
    localparam int EOSC_BAND_LSB      = 0;
    localparam int EOSC_IEN_BIT       = 7;
    localparam int EOSC_IRDY_BIT      = 6;
    localparam int EOSC_IDIV_LSB      = 0;

    // ============================================================
    // External oscillator mode codes
    localparam logic [2:0] EOSC_MODE_OFF0    = 3'h0;
    localparam logic [2:0] EOSC_MODE_OFF1    = 3'h1;
    localparam logic [2:0] EOSC_MODE_CMOS    = 3'h2;
    localparam logic [2:0] EOSC_MODE_CMOS_D2 = 3'h3;
    localparam logic [2:0] EOSC_MODE_RC      = 3'h4;
    localparam logic [2:0] EOSC_MODE_CAP     = 3'h5;
    localparam logic [2:0] EOSC_MODE_XTAL    = 3'h6;
    localparam logic [2:0] EOSC_MODE_XTAL_D2 = 3'h7;

    // Internal divider codes: 00 /8, 01 /4, 10 /2, 11 /1
    localparam logic [1:0] EOSC_IDIV_8 = 2'h0;
    localparam logic [1:0] EOSC_IDIV_4 = 2'h1;
    localparam logic [1:0] EOSC_IDIV_2 = 2'h2;
    localparam logic [1:0] EOSC_IDIV_1 = 2'h3;

    // Crystal must show this many oscillator edges with good amplitude
    localparam int EOSC_XTAL_SETTLE_EDGES = 1024;

    typedef enum logic [2:0] {
        EOSC_XV_IDLE   = 3'b001,
        EOSC_XV_SETTLE = 3'b010,
        EOSC_XV_VALID  = 3'b100
    } eosc_xv_e;

endpackage

// >>> logic/eosc_osc_if.sv
// Interface between the register block and the external oscillator front end
interface eosc_osc_if;
    logic [2:0] mode;
    logic       ext_tick;
    logic       xtal_valid;

    modport src (input mode, output ext_tick, output xtal_valid);
    modport snk (output mode, input ext_tick, input xtal_valid);
endinterface

// >>> logic/eosc_ext_osc.sv
// External oscillator front end: edge pulses, divide by 2, crystal settling
module eosc_ext_osc
    import eosc_pkg::*;
#(
    parameter int SETTLE_EDGES = EOSC_XTAL_SETTLE_EDGES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Oscillator signal and amplitude detector
    input  wire logic osc_sense,
    input  wire logic xtal_amp_ok,
    // Register block side
    eosc_osc_if.src   osc
);

    localparam int CW = $clog2(SETTLE_EDGES + 1);

    logic          prev_sense;
    logic          half;
    logic          tick;
    logic [CW-1:0] edge_cnt;
    eosc_xv_e      xv_state;
    logic          next_prev_sense;
    logic          next_half;
    logic          next_tick;
    logic [CW-1:0] next_edge_cnt;
    eosc_xv_e      next_xv_state;

    logic enabled;
    logic is_xtal;
    logic div2;
    logic rise;

    always_comb begin
        enabled = osc.mode[2] | osc.mode[1];
        is_xtal = osc.mode[2] & osc.mode[1];
        div2    = osc.mode == EOSC_MODE_CMOS_D2 || osc.mode == EOSC_MODE_XTAL_D2;
        rise    = enabled & osc_sense & ~prev_sense;
    end

    // ============================================================
    // Edge pulses; RC, capacitor and CMOS run at once, no settling
    always_comb begin
        // Track the pin while off too, so enabling on a high pin is no edge
        next_prev_sense = osc_sense;
        next_half       = half;
        next_tick       = 1'b0;
        if (!enabled) begin
            next_half = 1'b0;
        end else if (rise) begin
            if (div2) begin
                next_half = ~half;
                next_tick = half;
            end else begin
                next_tick = 1'b1;
            end
        end
    end

    // ============================================================
    // Crystal settling detector
    always_comb begin
        next_xv_state = xv_state;
        next_edge_cnt = edge_cnt;
        unique case (xv_state)
            EOSC_XV_IDLE: begin
                next_edge_cnt = '0;
                if (is_xtal) begin
                    next_xv_state = EOSC_XV_SETTLE;
                end
            end
            EOSC_XV_SETTLE: begin
                if (!is_xtal) begin
                    next_xv_state = EOSC_XV_IDLE;
                end else if (!xtal_amp_ok) begin
                    next_edge_cnt = '0;
                end else if (rise) begin
                    if (edge_cnt == CW'(SETTLE_EDGES - 1)) begin
                        next_xv_state = EOSC_XV_VALID;
                    end
                    next_edge_cnt = edge_cnt + CW'(1);
                end
            end
            EOSC_XV_VALID: begin
                // Losing amplitude restarts settling rather than staying valid
                if (!is_xtal) begin
                    next_xv_state = EOSC_XV_IDLE;
                end else if (!xtal_amp_ok) begin
                    next_xv_state = EOSC_XV_SETTLE;
                    next_edge_cnt = '0;
                end
            end
            default: begin
                next_xv_state = EOSC_XV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_sense <= 1'b0;
            half       <= 1'b0;
            tick       <= 1'b0;
            edge_cnt   <= '0;
            xv_state   <= EOSC_XV_IDLE;
        end else begin
            prev_sense <= next_prev_sense;
            half       <= next_half;
            tick       <= next_tick;
            edge_cnt   <= next_edge_cnt;
            xv_state   <= next_xv_state;
        end
    end

    assign osc.ext_tick   = tick;
    assign osc.xtal_valid = xv_state == EOSC_XV_VALID;

endmodule

// >>> logic/eosc_clock_ctrl.sv
// External oscillator control and system clock source selection
// Functional notes
// - Source select bit 1 takes system clock from external oscillator.
// - Select bit 0 takes internal oscillator scaled by its divider field.
// - External oscillator pulses stay available to peripherals regardless.
// - Hardware sets crystal valid once the crystal has settled.
// - RC and capacitor modes need no settling interval.
// - Valid flag bit 7 is read only, meaningful only in modes 11x.
// - Mode 00x off, 010 CMOS, 100 RC, 101 capacitor, 110 crystal.
// - Mode 011 CMOS divided by 2; 111 crystal divided by 2.
// - Bit 3 of the control register reads 0, writes ignored.
// - Bits 2..0 hold the frequency band, set to match crystal.
// - Crystal mode claims port 0 pins 2 and 3.
// - Capacitor, RC and CMOS modes claim only port 0 pin 3.
module eosc_clock_ctrl
    import eosc_pkg::*;
#(
    parameter int SETTLE_EDGES = EOSC_XTAL_SETTLE_EDGES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Oscillator sources
    input  wire logic       int_osc_tick,
    input  wire logic       int_osc_ready,
    input  wire logic       port0_bit3_in,
    input  wire logic       xtal_amp_ok,
    // Clock enables
    output logic            system_clock_signal,
    output logic            ext_osc_tick,
    // Oscillator controls and pin ownership
    output logic            int_osc_enable,
    output logic [2:0]      ext_osc_mode_field,
    output logic [2:0]      ext_osc_freq_band,
    output logic            osc_input_pin_claim,
    output logic            osc_output_pin_claim
);

    eosc_osc_if osc_bus ();

    eosc_ext_osc #(
        .SETTLE_EDGES (SETTLE_EDGES)
    ) u_ext (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .osc_sense   (port0_bit3_in),
        .xtal_amp_ok (xtal_amp_ok),
        .osc         (osc_bus.src)
    );

    // Mask of low divider count bits that must be all ones for a pulse
    function automatic logic [2:0] div_mask(input logic [1:0] code);
        unique case (code)
            EOSC_IDIV_8: div_mask = 3'h7;
            EOSC_IDIV_4: div_mask = 3'h3;
            EOSC_IDIV_2: div_mask = 3'h1;
            EOSC_IDIV_1: div_mask = 3'h0;
        endcase
    endfunction

    // ============================================================
    // Pin ownership
    // Crystal takes both pins; every other running mode only the
    // output-side pin
    function automatic logic takes_both_pins(input logic [2:0] code);
        takes_both_pins = code[2] & code[1];
    endfunction

    function automatic logic takes_out_pin(input logic [2:0] code);
        takes_out_pin = code[2] | code[1];
    endfunction

    // ============================================================
    // Registers
    logic       system_clock_signal_source_select;
    logic       int_en;
    logic [1:0] internal_osc_divider;
    logic [2:0] mode;
    logic [2:0] band;
    logic [7:0] rdata;
    logic [2:0] div_cnt;
    logic       sys_tick;
    logic       next_system_clock_signal_source_select;
    logic       next_int_en;
    logic [1:0] next_internal_osc_divider;
    logic [2:0] next_mode;
    logic [2:0] next_band;
    logic [7:0] next_rdata;
    logic [2:0] next_div_cnt;
    logic       next_sys_tick;
    logic [7:0] ext_ctrl_view;
    logic [7:0] int_ctrl_view;
    logic [7:0] clk_src_view;
    logic       int_div_tick;
    logic       in_claim;
    logic       out_claim;
    logic       next_in_claim;
    logic       next_out_claim;

    always_comb begin
        ext_ctrl_view = 8'h00;
        ext_ctrl_view[EOSC_XVALID_BIT] =
            osc_bus.xtal_valid & takes_both_pins(mode);
        ext_ctrl_view[EOSC_MODE_LSB +: 3] = mode;
        ext_ctrl_view[EOSC_BAND_LSB +: 3] = band;
        int_ctrl_view = 8'h00;
        int_ctrl_view[EOSC_IEN_BIT]  = int_en;
        int_ctrl_view[EOSC_IRDY_BIT] = int_en & int_osc_ready;
        int_ctrl_view[EOSC_IDIV_LSB +: 2] = internal_osc_divider;
        clk_src_view = 8'h00;
        clk_src_view[EOSC_SRC_SEL_BIT] = system_clock_signal_source_select;
    end

    // ============================================================
    // Register writes and registered read data
    always_comb begin
        next_system_clock_signal_source_select = system_clock_signal_source_select;
        next_int_en               = int_en;
        next_internal_osc_divider = internal_osc_divider;
        next_mode                 = mode;
        next_band                 = band;
        next_rdata                = rdata;
        if (sfr_wr) begin
            unique case (sfr_addr)
                EOSC_ADDR_CLK_SRC: begin
                    next_system_clock_signal_source_select =
                        sfr_wdata[EOSC_SRC_SEL_BIT];
                end
                EOSC_ADDR_INT_CTRL: begin
                    next_int_en = sfr_wdata[EOSC_IEN_BIT];
                    next_internal_osc_divider =
                        sfr_wdata[EOSC_IDIV_LSB +: 2];
                end
                EOSC_ADDR_EXT_CTRL: begin
                    // Bits 7 and 3 are dropped here
                    next_mode = sfr_wdata[EOSC_MODE_LSB +: 3];
                    next_band = sfr_wdata[EOSC_BAND_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
        if (sfr_rd) begin
            unique case (sfr_addr)
                EOSC_ADDR_CLK_SRC:  next_rdata = clk_src_view;
                EOSC_ADDR_INT_CTRL: next_rdata = int_ctrl_view;
                EOSC_ADDR_EXT_CTRL: next_rdata = ext_ctrl_view;
                default:            next_rdata = 8'h00;
            endcase
        end
        // Decoded from the next mode so the claims move with the field
        next_in_claim  = takes_both_pins(next_mode);
        next_out_claim = takes_out_pin(next_mode);
    end

    // ============================================================
    // Internal divider and source mux
    always_comb begin
        next_div_cnt = div_cnt;
        int_div_tick = 1'b0;
        if (int_en && int_osc_tick) begin
            next_div_cnt = div_cnt + 3'h1;
            int_div_tick = (div_cnt & div_mask(internal_osc_divider)) ==
                           div_mask(internal_osc_divider);
        end
        // Switching is glitch free by construction since both are enables;
        // software still must pick a settled source
        next_sys_tick = system_clock_signal_source_select ? osc_bus.ext_tick
                                             : int_div_tick;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            system_clock_signal_source_select <= EOSC_RST_CLK_SRC[EOSC_SRC_SEL_BIT];
            int_en               <= EOSC_RST_INT_CTRL[EOSC_IEN_BIT];
            internal_osc_divider <= EOSC_RST_INT_CTRL[EOSC_IDIV_LSB +: 2];
            mode                 <= EOSC_RST_EXT_CTRL[EOSC_MODE_LSB +: 3];
            band                 <= EOSC_RST_EXT_CTRL[EOSC_BAND_LSB +: 3];
            rdata                <= 8'h00;
            div_cnt              <= 3'h0;
            sys_tick             <= 1'b0;
            in_claim             <= 1'b0;
            out_claim            <= 1'b0;
        end else begin
            system_clock_signal_source_select <= next_system_clock_signal_source_select;
            int_en               <= next_int_en;
            internal_osc_divider <= next_internal_osc_divider;
            mode                 <= next_mode;
            band                 <= next_band;
            rdata                <= next_rdata;
            div_cnt              <= next_div_cnt;
            sys_tick             <= next_sys_tick;
            in_claim             <= next_in_claim;
            out_claim            <= next_out_claim;
        end
    end

    // ============================================================
    // Outputs
    assign osc_bus.mode         = mode;
    assign sfr_rdata            = rdata;
    assign system_clock_signal  = sys_tick;
    assign ext_osc_tick         = osc_bus.ext_tick;
    assign int_osc_enable       = int_en;
    assign ext_osc_mode_field   = mode;
    assign ext_osc_freq_band    = band;
    assign osc_input_pin_claim  = in_claim;
    assign osc_output_pin_claim = out_claim;

endmodule

// >>> test/eosc_clock_ctrl_chk.sv
// Checker: port properties of the clock control block
module eosc_clock_ctrl_chk
    import eosc_pkg::*;
#(
    parameter int SETTLE_EDGES = EOSC_XTAL_SETTLE_EDGES
) (
    // Clock and register port
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Clock path and controls
    input wire logic       int_osc_tick,
    input wire logic       port0_bit3_in,
    input wire logic       system_clock_signal,
    input wire logic       ext_osc_tick,
    input wire logic [2:0] ext_osc_mode_field,
    input wire logic [2:0] ext_osc_freq_band,
    input wire logic       osc_input_pin_claim,
    input wire logic       osc_output_pin_claim
);
    // ============================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic [2:0] md = ext_osc_mode_field;
    wire logic       xr = sfr_rd && sfr_addr == EOSC_ADDR_EXT_CTRL;
    wire logic       xw = sfr_wr && sfr_addr == EOSC_ADDR_EXT_CTRL;

    pin_in_a: assert property (
        osc_input_pin_claim == (md[2:1] == 2'h3)) else $error("pin 2 claim");
    pin_out_a: assert property (
        osc_output_pin_claim == (md[2:1] != 2'h0)) else $error("pin 3 claim");
    tick_off_a: assert property (
        ext_osc_tick |-> $past(md[2:1]) != 2'h0) else $error("tick when off");
    tick_rise_a: assert property (
        port0_bit3_in && !$past(port0_bit3_in)
        && md inside {3'h2, 3'h4, 3'h5, 3'h6} |=> ext_osc_tick)
        else $error("rise lost");
    tick_cause_a: assert property (ext_osc_tick |->
        $past(port0_bit3_in) && !$past(port0_bit3_in, 2))
        else $error("no rise");
    sys_cause_a: assert property (system_clock_signal |->
        $past(ext_osc_tick) || $past(int_osc_tick)) else $error("sys pulse");
    rsvd_bit_a: assert property (
        xr |=> sfr_rdata[3] == 1'b0) else $error("bit 3 set");
    valid_mode_a: assert property (xr && md[2:1] != 2'h3
        && $past(md[2:1]) != 2'h3 |=> !sfr_rdata[7]) else $error("valid");
    mode_wr_a: assert property (xw |=> md == $past(sfr_wdata[6:4])
        && ext_osc_freq_band == $past(sfr_wdata[2:0])) else $error("mode");
    cov_xtal: cover property (md == 3'h6 && system_clock_signal);
    cov_div: cover property (md == 3'h7 && ext_osc_tick);
    cov_int: cover property (int_osc_tick ##1 system_clock_signal);
endmodule

bind eosc_clock_ctrl eosc_clock_ctrl_chk #(.SETTLE_EDGES(SETTLE_EDGES)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .int_osc_tick(int_osc_tick), .port0_bit3_in(port0_bit3_in),
    .system_clock_signal(system_clock_signal), .ext_osc_tick(ext_osc_tick),
    .ext_osc_mode_field(ext_osc_mode_field),
    .ext_osc_freq_band(ext_osc_freq_band),
    .osc_input_pin_claim(osc_input_pin_claim),
    .osc_output_pin_claim(osc_output_pin_claim));

// >>> test/eosc_osc_model.sv
// Partner: gated external clock source with amplitude detector
module eosc_osc_model #(
    parameter int HALF = 3
) (
    // Clock
    input  wire logic clk,
    // Bench controls
    input  wire logic run,
    input  wire logic good,
    // Oscillator pin and detector
    output logic      osc_sig,
    output logic      amp_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Stands still low between runs, so each run gives whole periods
    always @(posedge clk) begin
        amp_ok <= good;
        if (!run) begin
            cnt <= 0;
            osc_sig <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            osc_sig <= !osc_sig;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> test/tb.sv
// Testbench: registers, clock paths and crystal settling
module tb
    import eosc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       int_osc_tick = 1'b0;
    logic       int_osc_ready = 1'b1;
    logic       run = 1'b0;
    logic       good = 1'b0;
    logic [7:0] sfr_rdata, rv;
    logic [2:0] mode, band;
    logic       osc_sig, amp_ok, sys_p, ext_t, in_cl, out_cl, int_en_o;
    int         errors = 0;
    int         samples_checked = 0;
    int         n_ext = 0;
    int         n_sys = 0;

    always #4 clk = ~clk;
    always @(posedge clk) begin
        n_ext <= n_ext + int'(ext_t);
        n_sys <= n_sys + int'(sys_p);
    end

    eosc_osc_model i_osc (.clk(clk), .run(run), .good(good),
        .osc_sig(osc_sig), .amp_ok(amp_ok));
    eosc_clock_ctrl #(.SETTLE_EDGES(4)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .int_osc_tick(int_osc_tick), .int_osc_ready(int_osc_ready),
        .port0_bit3_in(osc_sig), .xtal_amp_ok(amp_ok),
        .system_clock_signal(sys_p), .ext_osc_tick(ext_t),
        .int_osc_enable(int_en_o), .ext_osc_mode_field(mode),
        .ext_osc_freq_band(band), .osc_input_pin_claim(in_cl),
        .osc_output_pin_claim(out_cl));

    // ============================================================
    // Shared tasks
    task automatic close_out();
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask
    // Four whole periods of six cycles, then the source stands still
    task automatic run_osc();
        @(posedge clk) run <= 1'b1;
        repeat (24) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        rd(EOSC_ADDR_EXT_CTRL, rv);
        chk(rv, 8'h00);
        rd(EOSC_ADDR_CLK_SRC, rv);
        chk(rv, 8'h00);
        rd(EOSC_ADDR_INT_CTRL, rv);
        chk(rv, 8'hC0);
        rd(8'hB0, rv);
        chk(rv, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_modes();
        int e0;
        for (int m = 0; m < 8; m++) begin
            wr(EOSC_ADDR_EXT_CTRL, 8'h00);
            wr(EOSC_ADDR_EXT_CTRL, {1'b1, 3'(m), 1'b1, 3'(m)});
            rd(EOSC_ADDR_EXT_CTRL, rv);
            chk(rv, {1'b0, 3'(m), 1'b0, 3'(m)});
            chk({7'h00, in_cl}, {7'h00, m >= 6});
            chk({7'h00, out_cl}, {7'h00, m >= 2});
            chk({5'h00, mode}, 8'(m));
            chk({5'h00, band}, 8'(m));
            e0 = n_ext;
            run_osc();
            chk(8'(n_ext - e0), (m < 2) ? 8'h00 :
                (m == 3 || m == 7) ? 8'h02 : 8'h04);
        end
        $display("test modes done");
    endtask
    task automatic t_xtal();
        int k;
        int e0;
        int s0;
        good <= 1'b1;
        wr(EOSC_ADDR_EXT_CTRL, 8'h67);
        rd(EOSC_ADDR_EXT_CTRL, rv);
        chk(rv, 8'h67);
        @(posedge clk) run <= 1'b1;
        repeat (8) @(posedge clk);
        for (k = 0; k < 100 && rv[7] !== 1'b1; k++) rd(EOSC_ADDR_EXT_CTRL, rv);
        if (k == 100) begin
            errors++;
            close_out();
        end
        chk(rv, 8'hE7);
        run <= 1'b0;
        wr(EOSC_ADDR_CLK_SRC, 8'h01);
        e0 = n_ext;
        s0 = n_sys;
        run_osc();
        chk(8'(n_sys - s0), 8'(n_ext - e0));
        chk(8'(n_sys - s0), 8'h04);
        good <= 1'b0;
        repeat (3) @(posedge clk);
        rd(EOSC_ADDR_EXT_CTRL, rv);
        chk(rv, 8'h67);
        wr(EOSC_ADDR_CLK_SRC, 8'h00);
        $display("test crystal done");
    endtask
    task automatic t_intdiv();
        int s0;
        for (int d = 0; d < 5; d++) begin
            wr(EOSC_ADDR_INT_CTRL, (d < 4) ? {6'h20, 2'(d)} : 8'h00);
            rd(EOSC_ADDR_INT_CTRL, rv);
            chk(rv, (d < 4) ? {6'h30, 2'(d)} : 8'h00);
            chk({7'h00, int_en_o}, {7'h00, d < 4});
            s0 = n_sys;
            repeat (64) begin
                @(posedge clk) int_osc_tick <= 1'b1;
                @(posedge clk) int_osc_tick <= 1'b0;
            end
            repeat (3) @(posedge clk);
            chk(8'(n_sys - s0), (d < 4) ? 8'h08 << d : 8'h00);
        end
        $display("test divider done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_modes();
        t_xtal();
        t_intdiv();
        close_out();
    end
endmodule
